// *** hw/adc_serial_command_port.sv ***
/*
 * serial command port of a sigma-delta converter: command byte decode,
 * register shifting, continuous result reading and forty-ones reset,
 * all on the host serial clock, with the system side in conv_domain.
 * assumes the host drives sclk and din, and samples dout_rdy on the
 * rising sclk edge; the conversion engine supplies results on clk.
 */
// Contract
// - command register is 8 bits, write only; reads at select zero give status.
// - after the selected transfer completes the port waits for a command.
// - power-up and reset leave the port waiting for a command.
// - forty consecutive ones on din reset the whole part.
// - command byte arrives msb first and resets to zero.
// - a leading one is held in place; a zero starts seven command bits.
// - command bit 6 picks write (0) or read (1).
// - command bits 5 to 3 select the register.
// - select zero is command register on write, status on read, 8 bits.
// - transfer length follows the selected register: 8, 24 or 32 bits.
// - stream read shifts each new result after ready falls, no command.
// - command 01011100 enters continuous reading.
// - command 01011000 while ready is low leaves continuous reading.
// - din keeps being decoded during continuous reading.
// - the serial output doubles as the ready indicator.
// - ready clears on a new result and sets after it is read; a stream read ended by 01011000 leaves it low.
`timescale 1ns/10ps
`default_nettype none
module adc_serial_command_port #(
    parameter logic [7:0] IDENT_CODE = 8'ha3 // upper nibble arbitrary
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic din,
    output logic dout_rdy,
    input wire logic [23:0] result_data,
    input wire logic [6:0] result_flags,
    input wire logic result_valid,
    output logic part_reset,
    output logic [23:0] mode_word,
    output logic [23:0] config_word,
    output logic [7:0] pin_control,
    output logic [23:0] offset_word,
    output logic [23:0] gain_word
);
    import adc_cmd_pkg::*;

    domain_if dif ();

    adc_cmd_pkg::link_state_t state_ff, nxt_state;
    logic [5:0] cnt_ff, nxt_cnt;
    logic [5:0] ones_ff, nxt_ones;
    logic [7:0] cmd_sh_ff, nxt_cmd_sh;
    logic [7:0] cmd_ff, nxt_cmd;
    logic [31:0] rd_sh_ff, nxt_rd_sh;
    logic [23:0] mode_ff, nxt_mode;
    logic [23:0] config_ff, nxt_config;
    logic [7:0] pins_ff, nxt_pins;
    logic [23:0] offset_ff, nxt_offset;
    logic [23:0] gain_ff, nxt_gain;
    logic [23:0] wr_sh_ff;
    logic wr_tgl_ff, nxt_wr_tgl;
    logic rd_tgl_ff, nxt_rd_tgl;
    logic rst_tgl_ff, nxt_rst_tgl;
    logic busy_ff, nxt_busy;

    // read word, left aligned, for a select code
    function automatic logic [31:0] word_of(input logic [2:0] sel,
                                            input logic append);
        logic [31:0] w;
        w = 32'h00000000;
        if (sel == SEL_STATUS)
            w = {dif.status_w, 24'h000000};
        else if (sel == SEL_MODE)
            w = {mode_ff, 8'h00};
        else if (sel == SEL_CONFIG)
            w = {config_ff, 8'h00};
        else if (sel == SEL_RESULT)
            w = append ? {dif.result_w, dif.status_w} : {dif.result_w, 8'h00};
        else if (sel == SEL_IDENT)
            w = {IDENT_CODE, 24'h000000};
        else if (sel == SEL_PINS)
            w = {pins_ff, 24'h000000};
        else if (sel == SEL_OFFSET)
            w = {offset_ff, 8'h00};
        else
            w = {gain_ff, 8'h00};
        return w;
    endfunction : word_of

    // transfer length in bits for a select code
    function automatic logic [5:0] len_of(input logic [2:0] sel,
                                          input logic append);
        logic [5:0] n;
        n = LEN_WORD;
        if (sel == SEL_STATUS || sel == SEL_IDENT || sel == SEL_PINS)
            n = LEN_BYTE;
        else if (sel == SEL_RESULT)
            n = append ? LEN_APPEND : LEN_WORD;
        return n;
    endfunction : len_of

    // command and data decode
    wire append = mode_ff[MODE_APPEND_BIT];
    wire [7:0] rx_byte = {cmd_sh_ff[6:0], din};
    wire [7:0] new_cmd = {1'b0, cmd_sh_ff[5:0], din};
    wire new_read = new_cmd[CMD_RW_BIT];
    wire [2:0] new_sel = new_cmd[CMD_SEL_MSB:CMD_SEL_LSB];
    wire [2:0] cur_sel = cmd_ff[CMD_SEL_MSB:CMD_SEL_LSB];
    wire [5:0] cur_len = len_of(cur_sel, append);
    wire last_bit = (cnt_ff == cur_len - 6'd1);
    wire [23:0] wr_word = {wr_sh_ff[22:0], din};
    wire ones_full = din & (ones_ff == RESET_ONES - 6'd1);
    wire [31:0] stream_word = word_of(SEL_RESULT, append);
    wire rdy = dif.status_w[STATUS_RDY_BIT];
    wire shifting = (state_ff == LINK_READ) ||
                    (state_ff == LINK_STREAM && cnt_ff != 6'd0);
    wire stream_wait = (state_ff == LINK_STREAM) && (cnt_ff == 6'd0) && !rdy;

    // serial output: data while shifting or while a stream result waits, ready level otherwise
    assign dout_rdy = shifting ? rd_sh_ff[31] :
                      stream_wait ? stream_word[31] :
                      rdy;

    // next state of the serial link
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_cmd = cmd_ff;
        nxt_cmd_sh = rx_byte;
        nxt_rd_sh = {rd_sh_ff[30:0], 1'b0};
        nxt_mode = mode_ff;
        nxt_config = config_ff;
        nxt_pins = pins_ff;
        nxt_offset = offset_ff;
        nxt_gain = gain_ff;
        nxt_wr_tgl = wr_tgl_ff;
        nxt_rd_tgl = rd_tgl_ff;
        nxt_rst_tgl = rst_tgl_ff;
        nxt_ones = din ? ones_ff + 6'd1 : 6'd0;
        case (state_ff)
            LINK_IDLE:
            begin
                if (!din)
                begin
                    nxt_state = LINK_CMD;
                    nxt_cnt = 6'd0;
                end
            end
            LINK_CMD:
            begin
                if (cnt_ff == CMD_TAIL_BITS - 6'd1)
                begin
                    nxt_cmd = new_cmd;
                    nxt_cnt = 6'd0;
                    if (new_cmd == CMD_STREAM_ON)
                        nxt_state = LINK_STREAM;
                    else if (new_read)
                    begin
                        nxt_state = LINK_READ;
                        nxt_rd_sh = word_of(new_sel, append);
                    end
                    else if (new_sel == SEL_STATUS)
                        nxt_state = LINK_IDLE;
                    else
                        nxt_state = LINK_WRITE;
                end
                else
                    nxt_cnt = cnt_ff + 6'd1;
            end
            LINK_WRITE:
            begin
                if (last_bit)
                begin
                    nxt_state = LINK_IDLE;
                    nxt_wr_tgl = ~wr_tgl_ff;
                    if (cur_sel == SEL_MODE)
                        nxt_mode = wr_word;
                    else if (cur_sel == SEL_CONFIG)
                        nxt_config = wr_word;
                    else if (cur_sel == SEL_PINS)
                        nxt_pins = wr_word[7:0];
                    else if (cur_sel == SEL_OFFSET)
                        nxt_offset = wr_word;
                    else if (cur_sel == SEL_GAIN)
                        nxt_gain = wr_word;
                end
                else
                    nxt_cnt = cnt_ff + 6'd1;
            end
            LINK_READ:
            begin
                if (last_bit)
                begin
                    nxt_state = LINK_IDLE;
                    if (cur_sel == SEL_RESULT)
                        nxt_rd_tgl = ~rd_tgl_ff;
                end
                else
                    nxt_cnt = cnt_ff + 6'd1;
            end
            LINK_STREAM:
            begin
                if (cnt_ff[2:0] == 3'h7 && rx_byte == CMD_STREAM_OFF)
                begin
                    nxt_state = LINK_IDLE;
                    nxt_cnt = 6'd0;
                end
                else if (cnt_ff == 6'd0)
                begin
                    nxt_rd_sh = {stream_word[30:0], 1'b0};
                    nxt_cnt = 6'd1;
                end
                else if (cnt_ff == len_of(SEL_RESULT, append) - 6'd1)
                begin
                    nxt_cnt = 6'd0;
                    nxt_rd_tgl = ~rd_tgl_ff;
                end
                else
                    nxt_cnt = cnt_ff + 6'd1;
            end
            default:
            begin
                nxt_state = LINK_IDLE;
            end
        endcase
        if (ones_full)
        begin
            nxt_state = LINK_IDLE;
            nxt_cnt = 6'd0;
            nxt_ones = 6'd0;
            nxt_cmd = CMD_RESET;
            nxt_mode = MODE_RESET;
            nxt_config = CONFIG_RESET;
            nxt_pins = PINS_RESET;
            nxt_offset = OFFSET_RESET;
            nxt_gain = GAIN_RESET;
            nxt_rst_tgl = ~rst_tgl_ff;
        end
        nxt_busy = (nxt_state == LINK_READ) || (nxt_state == LINK_CMD) ||
                   (nxt_state == LINK_STREAM && nxt_cnt != 6'd0);
    end

    // link sequencing registers
    always_ff @(posedge sclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= LINK_IDLE;
            cnt_ff <= 6'd0;
            ones_ff <= 6'd0;
            cmd_sh_ff <= CMD_RESET;
            cmd_ff <= CMD_RESET;
            busy_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            ones_ff <= nxt_ones;
            cmd_sh_ff <= nxt_cmd_sh;
            cmd_ff <= nxt_cmd;
            busy_ff <= nxt_busy;
        end
    end

    // shift registers and event toggles
    always_ff @(posedge sclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_sh_ff <= 32'h00000000;
            wr_sh_ff <= 24'h000000;
            wr_tgl_ff <= 1'b0;
            rd_tgl_ff <= 1'b0;
            rst_tgl_ff <= 1'b0;
        end
        else
        begin
            rd_sh_ff <= nxt_rd_sh;
            wr_sh_ff <= wr_word;
            wr_tgl_ff <= nxt_wr_tgl;
            rd_tgl_ff <= nxt_rd_tgl;
            rst_tgl_ff <= nxt_rst_tgl;
        end
    end

    // writable registers held on the link side
    always_ff @(posedge sclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_ff <= MODE_RESET;
            config_ff <= CONFIG_RESET;
            pins_ff <= PINS_RESET;
            offset_ff <= OFFSET_RESET;
            gain_ff <= GAIN_RESET;
        end
        else
        begin
            mode_ff <= nxt_mode;
            config_ff <= nxt_config;
            pins_ff <= nxt_pins;
            offset_ff <= nxt_offset;
            gain_ff <= nxt_gain;
        end
    end

    // words and toggles toward the system clock
    assign dif.mode_w = mode_ff;
    assign dif.config_w = config_ff;
    assign dif.pins_w = pins_ff;
    assign dif.offset_w = offset_ff;
    assign dif.gain_w = gain_ff;
    assign dif.wr_tgl = wr_tgl_ff;
    assign dif.rd_done_tgl = rd_tgl_ff;
    assign dif.reset_tgl = rst_tgl_ff;
    assign dif.busy = busy_ff;

    conv_domain u_conv (
        .clk(clk),
        .rst_b(rst_b),
        .dif(dif),
        .result_data(result_data),
        .result_flags(result_flags),
        .result_valid(result_valid),
        .part_reset(part_reset),
        .mode_word(mode_word),
        .config_word(config_word),
        .pin_control(pin_control),
        .offset_word(offset_word),
        .gain_word(gain_word)
    );
endmodule : adc_serial_command_port
`default_nettype wire

// *** shared/adc_cmd_pkg.sv ***
/*
 * constants and types of the serial command port: register select codes,
 * field positions, reset values, special command bytes and link states.
 * assumes nothing of its surroundings.
 */
`default_nettype none
package adc_cmd_pkg;
    // register select codes carried in the command byte
    localparam logic [2:0] SEL_STATUS = 3'h0;
    localparam logic [2:0] SEL_MODE = 3'h1;
    localparam logic [2:0] SEL_CONFIG = 3'h2;
    localparam logic [2:0] SEL_RESULT = 3'h3;
    localparam logic [2:0] SEL_IDENT = 3'h4;
    localparam logic [2:0] SEL_PINS = 3'h5;
    localparam logic [2:0] SEL_OFFSET = 3'h6;
    localparam logic [2:0] SEL_GAIN = 3'h7;
    // field positions
    localparam int CMD_RW_BIT = 6;
    localparam int CMD_SEL_MSB = 5;
    localparam int CMD_SEL_LSB = 3;
    localparam int CMD_STREAM_BIT = 2;
    localparam int MODE_APPEND_BIT = 20;
    localparam int STATUS_RDY_BIT = 7;
    // reset values
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam logic [23:0] MODE_RESET = 24'h080060;
    localparam logic [23:0] CONFIG_RESET = 24'h000117;
    localparam logic [7:0] PINS_RESET = 8'h00;
    localparam logic [23:0] OFFSET_RESET = 24'h800000;
    localparam logic [23:0] GAIN_RESET = 24'h500000;
    localparam logic [23:0] RESULT_RESET = 24'h000000;
    localparam logic [3:0] IDENT_LOW = 4'h3;
    // special command bytes and counts
    localparam logic [7:0] CMD_STREAM_ON = 8'h5c;
    localparam logic [7:0] CMD_STREAM_OFF = 8'h58;
    localparam logic [5:0] RESET_ONES = 6'd40;
    localparam logic [5:0] CMD_TAIL_BITS = 6'd7;
    localparam logic [5:0] LEN_BYTE = 6'd8;
    localparam logic [5:0] LEN_WORD = 6'd24;
    localparam logic [5:0] LEN_APPEND = 6'd32;
    // states of the serial link
    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_CMD,
        LINK_WRITE,
        LINK_READ,
        LINK_STREAM
    } link_state_t;
endpackage : adc_cmd_pkg
`default_nettype wire

// *** shared/domain_if.sv ***
/*
 * signals passed between the serial-clock logic and the system-clock logic.
 * assumes words are held stable around their toggle events.
 */
`timescale 1ns/10ps
`default_nettype none
interface domain_if;
    logic [23:0] mode_w;
    logic [23:0] config_w;
    logic [23:0] offset_w;
    logic [23:0] gain_w;
    logic [7:0] pins_w;
    logic wr_tgl;
    logic rd_done_tgl;
    logic reset_tgl;
    logic busy;
    logic [23:0] result_w;
    logic [7:0] status_w;
    modport link (
        output mode_w, config_w, offset_w, gain_w, pins_w,
        output wr_tgl, rd_done_tgl, reset_tgl, busy,
        input result_w, status_w
    );
    modport conv (
        input mode_w, config_w, offset_w, gain_w, pins_w,
        input wr_tgl, rd_done_tgl, reset_tgl, busy,
        output result_w, status_w
    );
endinterface : domain_if
`default_nettype wire

// *** hw/conv_domain.sv ***
/*
 * system-clock side: mirrors written registers, holds the conversion
 * result and the ready flag, and raises the part reset.
 * assumes the link side holds its words stable around each toggle.
 */
`timescale 1ns/10ps
`default_nettype none
module conv_domain (
    input wire logic clk,
    input wire logic rst_b,
    domain_if.conv dif,
    input wire logic [23:0] result_data,
    input wire logic [6:0] result_flags,
    input wire logic result_valid,
    output logic part_reset,
    output logic [23:0] mode_word,
    output logic [23:0] config_word,
    output logic [7:0] pin_control,
    output logic [23:0] offset_word,
    output logic [23:0] gain_word
);
    import adc_cmd_pkg::*;

    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] sync3_ff;
    logic [23:0] stage_ff;
    logic [6:0] stage_flags_ff;
    logic new_ff;
    logic [23:0] result_ff;
    logic [7:0] status_ff;
    wire [3:0] link_in = {dif.busy, dif.reset_tgl, dif.rd_done_tgl, dif.wr_tgl};
    wire wr_evt = sync2_ff[0] ^ sync3_ff[0];
    wire rd_evt = sync2_ff[1] ^ sync3_ff[1];
    wire rst_evt = sync2_ff[2] ^ sync3_ff[2];
    wire link_busy = sync2_ff[3];
    wire publish = new_ff & ~link_busy;

    // two-flop synchronisers, third flop only for edge detection
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sync
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                    sync3_ff[gi] <= 1'b0;
                end
                else
                begin
                    sync1_ff[gi] <= link_in[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    sync3_ff[gi] <= sync2_ff[gi];
                end
            end
        end
    endgenerate

    // register mirrors, reloaded on the forty-ones reset
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_word <= MODE_RESET;
            config_word <= CONFIG_RESET;
            pin_control <= PINS_RESET;
            offset_word <= OFFSET_RESET;
            gain_word <= GAIN_RESET;
            part_reset <= 1'b0;
        end
        else
        begin
            part_reset <= rst_evt;
            if (rst_evt)
            begin
                mode_word <= MODE_RESET;
                config_word <= CONFIG_RESET;
                pin_control <= PINS_RESET;
                offset_word <= OFFSET_RESET;
                gain_word <= GAIN_RESET;
            end
            else if (wr_evt)
            begin
                mode_word <= dif.mode_w;
                config_word <= dif.config_w;
                pin_control <= dif.pins_w;
                offset_word <= dif.offset_w;
                gain_word <= dif.gain_w;
            end
        end
    end

    // results are staged and published only while no read is shifting
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage_ff <= RESULT_RESET;
            stage_flags_ff <= 7'h00;
            new_ff <= 1'b0;
        end
        else
        begin
            if (result_valid)
            begin
                stage_ff <= result_data;
                stage_flags_ff <= result_flags;
            end
            new_ff <= result_valid | (new_ff & ~publish & ~rst_evt);
        end
    end

    // ready flag: a new result clears it, a result read not ended by CMD_STREAM_OFF sets it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            result_ff <= RESULT_RESET;
            status_ff <= STATUS_RESET;
        end
        else if (rst_evt)
        begin
            result_ff <= RESULT_RESET;
            status_ff <= STATUS_RESET;
        end
        else if (publish)
        begin
            result_ff <= stage_ff;
            status_ff <= {1'b0, stage_flags_ff};
        end
        else if (rd_evt)
        begin
            status_ff[STATUS_RDY_BIT] <= 1'b1;
        end
    end

    assign dif.result_w = result_ff;
    assign dif.status_w = status_ff;
endmodule : conv_domain
`default_nettype wire

// *** test/adc_serial_command_port_sva.sv ***
/*
 * checker of the serial command port, bound to its ports.
 * assumes sclk rests still between frames.
 */
`timescale 1ns/10ps
`default_nettype none
module adc_port_sva
    import adc_cmd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout_rdy,
    input wire logic [23:0] result_data,
    input wire logic result_valid,
    input wire logic part_reset,
    input wire logic [23:0] mode_word,
    input wire logic [23:0] config_word,
    input wire logic [7:0] pin_control,
    input wire logic [23:0] offset_word,
    input wire logic [23:0] gain_word
);
    logic [5:0] ones_ff;
    logic [3:0] quiet_ff;
    logic sclk_ff;
    // ones run on din, clk cycles since sclk moved
    wire logic hit40 = (ones_ff == RESET_ONES);
    wire logic [5:0] nxt_ones = !din ? 6'h00 : (hit40 ? ones_ff : ones_ff + 6'h01);
    wire logic quiet = (quiet_ff >= 4'hc);
    wire logic [3:0] nxt_quiet = (sclk != sclk_ff) ? 4'h0 : quiet_ff + {3'h0, !(&quiet_ff)};
    // on sclk
    always_ff @(posedge sclk or negedge rst_b)
    begin
        if (!rst_b)
            ones_ff <= 6'h00;
        else
            ones_ff <= nxt_ones;
    end
    // on clk
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclk_ff <= 1'b1;
            quiet_ff <= 4'h0;
        end
        else
        begin
            sclk_ff <= sclk;
            quiet_ff <= nxt_quiet;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_reset_pulse: assert property (part_reset |=> !part_reset)
        else $error("reset too long");
    a_ones_reset: assert property ($rose(hit40) |-> ##[1:8] part_reset)
        else $error("no part reset");
    a_reset_cause: assert property (part_reset |-> hit40)
        else $error("stray part reset");
    a_words_reset: assert property (part_reset |-> ##[0:4] (mode_word == MODE_RESET
        && config_word == CONFIG_RESET && offset_word == OFFSET_RESET
        && gain_word == GAIN_RESET))
        else $error("words not reset");
    a_pins_reset: assert property (part_reset |-> ##[0:4] pin_control == PINS_RESET)
        else $error("pins not reset");
    a_reset_ready: assert property (part_reset && !result_valid |-> ##[0:4] dout_rdy)
        else $error("ready low after reset");
    a_ready_cause: assert property ($fell(dout_rdy) && quiet |->
        $past(result_valid, 1) || $past(result_valid, 2) || $past(result_valid, 3))
        else $error("stray ready fall");
    a_valid_clear: assert property (
        result_valid && quiet && !result_data[23] |-> ##[1:3] !dout_rdy)
        else $error("ready did not fall");
    a_words_hold: assert property (quiet && !part_reset |=> $stable(mode_word)
        && $stable(config_word) && $stable(offset_word) && $stable(gain_word)
        && $stable(pin_control))
        else $error("word moved");
    c_part_reset: cover property (part_reset);
    c_ready_fall: cover property (result_valid ##[1:3] !dout_rdy);
    c_word_write: cover property ($changed(mode_word) && !part_reset);
endmodule : adc_port_sva
bind adc_serial_command_port adc_port_sva chk (.*);
`default_nettype wire

// *** test/host_model.sv ***
/*
 * host model: sclk only in frames, drives din.
 * assumes one frame at a time.
 */
`timescale 1ns/10ps
`default_nettype none
module host_model (
    output logic sclk,
    output logic din,
    input wire logic dout_rdy
);
    // sclk rests high, din starts high and then idles at park
    initial
    begin
        sclk = 1'b1;
        din = 1'b1;
    end
    // n bits msb first, dout_rdy taken before each rise
    task automatic xbits(input logic [39:0] tx, input int n, input logic park,
        output logic [39:0] rx);
        rx = '0;
        #1.5;
        for (int i = n - 1; i >= 0; i--)
        begin
            sclk = 1'b0;
            din = tx[i];
            #6;
            rx = {rx[38:0], dout_rdy};
            sclk = 1'b1;
            #6;
        end
        din = park;
    endtask : xbits
endmodule : host_model
`default_nettype wire

// *** test/adc_serial_command_port_test.sv ***
/*
 * bench of the serial command port.
 * assumes a host model and the bound checker.
 */
`timescale 1ns/10ps
`default_nettype none
`define check_eq(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module adc_serial_command_port_test;
    import adc_cmd_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h93; // upper nibble arbitrary
    localparam logic [31:0] RST_V [8] = '{32'(STATUS_RESET), 32'(MODE_RESET), 32'(CONFIG_RESET),
        32'(RESULT_RESET), 32'({ID_VAL[7:4], IDENT_LOW}), 32'(PINS_RESET), 32'(OFFSET_RESET),
        32'(GAIN_RESET)};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [23:0] result_data = 24'h000000;
    logic [6:0] result_flags = 7'h00;
    logic result_valid = 1'b0;
    wire logic sclk, din, dout_rdy, part_reset;
    wire logic [23:0] mode_word, config_word, offset_word, gain_word;
    wire logic [7:0] pin_control;
    int fail_count = 0, checks_done = 0, cycles = 0;
    logic seen_reset = 1'b0, park = 1'b1;
    logic [31:0] v;
    logic [23:0] wv;
    logic [39:0] rx;
    logic [2:0] wsel [5] = '{SEL_MODE, SEL_CONFIG, SEL_PINS, SEL_OFFSET, SEL_GAIN};
    always #2 clk = ~clk;
    adc_serial_command_port #(.IDENT_CODE(ID_VAL)) DUT (.*);
    host_model host (.*);
    // cycle ceiling and part reset watch
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (part_reset === 1'b1)
            seen_reset <= 1'b1;
        if (cycles == 30000)
        begin
            fail_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("mismatches %0d of %0d checks", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    function automatic int len(input logic [2:0] s);
        len = (s == SEL_STATUS || s == SEL_IDENT || s == SEL_PINS) ? 8 : 24;
    endfunction : len
    function automatic logic [23:0] mirror(input logic [2:0] s);
        case (s)
            SEL_MODE: mirror = mode_word;
            SEL_CONFIG: mirror = config_word;
            SEL_PINS: mirror = {16'h0000, pin_control};
            SEL_OFFSET: mirror = offset_word;
            default: mirror = gain_word;
        endcase
    endfunction : mirror
    // command byte then n data bits
    task automatic xfer(input logic [7:0] cmd, input logic [31:0] wd, input int n,
        output logic [31:0] v);
        logic [39:0] rx;
        host.xbits(({32'h0, cmd} << n) | {8'h00, wd}, n + 8, park, rx);
        v = rx[31:0] & ~(32'hffffffff << n);
    endtask : xfer
    // new result on a quiet link
    task automatic pulse(input logic [23:0] d, input logic [6:0] f);
        repeat (16) @(posedge clk);
        result_data <= d;
        result_flags <= f;
        result_valid <= 1'b1;
        @(posedge clk);
        result_valid <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse
    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        for (int s = 0; s < 8; s++)
        begin
            xfer({2'b01, s[2:0], 3'b000}, 32'h0, len(s[2:0]), v);
            `check_eq("reset value", RST_V[s], v)
        end
        host.xbits(40'h7, 3, 1'b1, rx);
        xfer(8'h00, 32'h0, 0, v);
        foreach (wsel[i])
        begin
            wv = 24'h0c96a5 ^ {21'h0, wsel[i]};
            if (len(wsel[i]) == 8)
                wv[23:8] = 16'h0000;
            xfer({2'b00, wsel[i], 3'b000}, {8'h00, wv}, len(wsel[i]), v);
            repeat (10) @(posedge clk);
            `check_eq("mirror", wv, mirror(wsel[i]))
            xfer({2'b01, wsel[i], 3'b000}, 32'h0, len(wsel[i]), v);
            `check_eq("read back", {8'h00, wv}, v)
        end
        xfer(8'h20, 32'h5a, 8, v);
        xfer(8'h60, 32'h0, 8, v);
        `check_eq("identity", RST_V[SEL_IDENT], v)
        pulse(24'h3c5a96, 7'h15);
        `check_eq("ready pin", 1'b0, dout_rdy)
        xfer(8'h58, 32'h0, 24, v);
        `check_eq("result", 32'h3c5a96, v)
        repeat (6) @(posedge clk);
        `check_eq("ready again", 1'b1, dout_rdy)
        xfer(8'h08, {8'h00, MODE_RESET | 24'h100000}, 24, v);
        pulse(24'h5a0f33, 7'h2c);
        xfer(8'h58, 32'h0, 32, v);
        `check_eq("result and status", {24'h5a0f33, 1'b0, 7'h2c}, v)
        xfer(8'h08, {8'h00, MODE_RESET}, 24, v);
        park = 1'b0;
        xfer(CMD_STREAM_ON, 32'h0, 0, v);
        pulse(24'h4d2e1b, 7'h01);
        `check_eq("stream ready", 1'b0, dout_rdy)
        host.xbits(40'h0, 24, 1'b0, rx);
        `check_eq("stream word", 24'h4d2e1b, rx[23:0])
        repeat (6) @(posedge clk);
        `check_eq("stream idle", 1'b1, dout_rdy)
        pulse(24'h1b7c40, 7'h01);
        park = 1'b1;
        host.xbits({32'h0, CMD_STREAM_OFF}, 24, 1'b1, rx);
        `check_eq("last word", 24'h1b7c40, rx[23:0])
        xfer(8'h60, 32'h0, 8, v);
        `check_eq("after stream", RST_V[SEL_IDENT], v)
        host.xbits(40'h10, 8, 1'b1, rx);
        host.xbits({40{1'b1}}, 40, 1'b1, rx);
        for (int i = 0; i < 20 && !seen_reset; i++)
            @(posedge clk);
        repeat (6) @(posedge clk);
        `check_eq("part reset", 1'b1, seen_reset)
        `check_eq("config after ones", CONFIG_RESET, config_word)
        xfer(8'h40, 32'h0, 8, v);
        `check_eq("idle after ones", RST_V[SEL_STATUS], v)
        stop_test();
    end
endmodule : adc_serial_command_port_test
`default_nettype wire
